// ### pkg/cdb_defs.svh
// Constants for the class D bridge control block: offsets, fields, thresholds.
// Assumes a 20 MHz core clock; included by the core.
`ifndef CDB_DEFS_SVH
`define CDB_DEFS_SVH

// Core clock rate in kHz, so that ms times kHz gives cycles
`define CDB_MCLK_KHZ        20000
// Data-loss window in ms
`define CDB_DATALOSS_MS     50
// Die temperature thresholds in degrees C (135, 150, 120)
`define CDB_TEMP_WARN_C     8'h87
`define CDB_TEMP_SHUT_C     8'h96
`define CDB_TEMP_CLEAR_C    8'h78
// Current limit in A; the sense comparators trip at this level
`define CDB_OC_LIMIT_A      5
// Dead-time ticks per nonoverlap step
`define CDB_NOV_STEP_TICKS  5'h02

// Register offsets (byte addresses)
`define CDB_REG_CTRL        8'h00
`define CDB_REG_STATUS      8'h04
`define CDB_REG_CONFIG      8'h08

// Control fields
`define CDB_CTRL_SOFTMUTE   0
// Status fields
`define CDB_ST_DATALOSS     0
`define CDB_ST_OVERCURRENT  1
`define CDB_ST_THERMWARN    2
`define CDB_ST_THERMSHUT    3
`define CDB_ST_POWERDOWN    4
`define CDB_ST_MUTED        5
// Config fields
`define CDB_CFG_CLKSRC      0
`define CDB_CFG_CHMODE      1
`define CDB_CFG_EDGE_LSB    4
`define CDB_CFG_NOV_LSB     8
// Reset values
`define CDB_CTRL_RESET      1'h0

`endif

// ### pkg/cdb_pkg.sv
// Types shared by the class D bridge control block.
// Assumes cdb_defs.svh is on the include path.
`default_nettype none
package cdb_pkg;
  // Pin inputs travelling together through the synchroniser
  typedef struct packed {
    logic       driveInA;
    logic       driveInB;
    logic       driveInC;
    logic       driveInD;
    logic       muteN;
    logic       resetPowerdownN;
    logic       extClk;
    logic [3:0] errIn;
    logic       clockSourceStrap;
    logic       channelModeStrap;
  } cdb_pins_s;

  // Device operating state, one-hot
  typedef enum logic [2:0] {
    ST_PDN  = 3'h1,
    ST_RUN  = 3'h2,
    ST_HALT = 3'h4
  } cdb_state_e;
endpackage
`default_nettype wire

// ### core/cdb_bridge_ctrl.sv
// Digital control of a four-pair class D output stage with dead time,
// strap capture, thermal, overcurrent and data-loss protection.
// Assumes pin inputs are asynchronous; sense inputs share mclk.
//
// Contract
// - Dead time between complementary gate switching
// - Mode straps latched at reset release
// - Clock strap: 0 internal, 1 external
// - Mode strap: 0 bridge, 1 four-channel
// - Bridge mode: A drives AB, C drives CD
// - Bridge mode: data loss after 50 ms
// - Four-channel: each input drives own output
// - Four-channel: low pin disables low sides
// - Thermal warning above 135 C
// - Thermal shutdown above 150 C stops switching
// - Thermal flags clear below 120 C
// - Overcurrent mutes and raises flag
// - Overcurrent latched until reset or mute cycle
// - Edge speed pins captured at reset rise
// - Edge index is pins, inverted B, plus one
// - Nonoverlap pins captured at reset rise
// - Nonoverlap index is pins, inverted D, plus one
// - Error pins are straps, then driven outputs
// - Error indications active low
// - Reset and power-down active low
// - Mute input active low
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`include "cdb_defs.svh"
`default_nettype none
module cdb_bridge_ctrl
  import cdb_pkg::*;
#(
  parameter int DATALOSS_CYC = `CDB_DATALOSS_MS * `CDB_MCLK_KHZ
)(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        driveInA,
  input  wire logic        driveInB,
  input  wire logic        driveInC,
  input  wire logic        driveInD,
  input  wire logic        muteN,
  input  wire logic        resetPowerdownN,
  input  wire logic        extClk,
  input  wire logic        clockSourceStrap,
  input  wire logic        channelModeStrap,
  input  wire logic [7:0]  dieTempC,
  input  wire logic [7:0]  currentLimitHit,
  input  wire logic        datalossOrLowsideIn,
  output logic             datalossOrLowsideOut,
  output logic             datalossOrLowsideOe,
  input  wire logic        overcurrentFlagNIn,
  output logic             overcurrentFlagNOut,
  output logic             overcurrentFlagNOe,
  input  wire logic        thermalWarnNIn,
  output logic             thermalWarnNOut,
  output logic             thermalWarnNOe,
  input  wire logic        thermalShutdownNIn,
  output logic             thermalShutdownNOut,
  output logic             thermalShutdownNOe,
  output logic [3:0]       bridgeOutHi,
  output logic [3:0]       bridgeOutLo,
  output logic [3:0]       edgeSpeedIdx,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [31:0]      regRdata
);

  localparam int DL_W = $clog2(DATALOSS_CYC + 1);

  // Index from two upper pins and an inverted low pin, plus one: 1..8
  function automatic logic [3:0] strapIndex(input logic b2, input logic b1, input logic b0);
    strapIndex = {1'b0, b2, b1, ~b0} + 4'h1;
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  cdb_pins_s pinRaw;
  cdb_pins_s sync1_reg;
  cdb_pins_s sync2_reg;
  cdb_pins_s sync3_reg;
  cdb_pins_s pin_reg;
  cdb_pins_s pin_next;

  assign pinRaw = '{driveInA, driveInB, driveInC, driveInD, muteN, resetPowerdownN, extClk,
                    {thermalShutdownNIn, thermalWarnNIn, overcurrentFlagNIn, datalossOrLowsideIn},
                    clockSourceStrap, channelModeStrap};

  // A bit changes only once the second and third stages agree
  assign pin_next = (~(sync2_reg ^ sync3_reg) & sync2_reg) | ((sync2_reg ^ sync3_reg) & pin_reg);

  // Reset to idle pin levels so that no false mute edge follows reset;
  // the power-down pin starts held low so the straps are tracked first
  localparam cdb_pins_s PIN_IDLE = '{muteN: 1'h1, errIn: 4'hF, default: '0};

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= PIN_IDLE;
      sync2_reg <= PIN_IDLE;
      sync3_reg <= PIN_IDLE;
      pin_reg   <= PIN_IDLE;
    end
    else
    begin
      sync1_reg <= pinRaw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= pin_next;
    end
  end

  // ************************************************************
  // Operating state and strap capture
  // ************************************************************
  cdb_state_e state_reg;
  logic       clkSrc_reg;
  logic       chanMode_reg;
  logic [3:0] novIdx_reg;
  logic       softMute_reg;
  logic       thermWarn_reg;
  logic       thermShut_reg;
  logic       ocLatch_reg;
  logic       dataLoss_reg;
  logic       muteRise;
  logic       muteSeen_reg;
  logic       halt;

  assign halt = thermShut_reg | ocLatch_reg | ~pin_reg.muteN | softMute_reg;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= ST_PDN;
    else
    begin
      case (state_reg)
        ST_PDN:  state_reg <= pin_reg.resetPowerdownN ? ST_RUN : ST_PDN;
        ST_RUN:  state_reg <= !pin_reg.resetPowerdownN ? ST_PDN : (halt ? ST_HALT : ST_RUN);
        ST_HALT: state_reg <= !pin_reg.resetPowerdownN ? ST_PDN : (halt ? ST_HALT : ST_RUN);
        default: state_reg <= ST_PDN;
      endcase
    end
  end

  // Straps track pins while held down and freeze at the release
  // Mode strap capture
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clkSrc_reg   <= 1'h0;
      chanMode_reg <= 1'h0;
      edgeSpeedIdx <= 4'h1;
      novIdx_reg   <= 4'h1;
    end
    else if (state_reg == ST_PDN)
    begin
      clkSrc_reg   <= pin_reg.clockSourceStrap;
      chanMode_reg <= pin_reg.channelModeStrap;
      edgeSpeedIdx <= strapIndex(pin_reg.errIn[3], pin_reg.errIn[2], pin_reg.driveInB);
      novIdx_reg   <= strapIndex(pin_reg.errIn[1], pin_reg.errIn[0], pin_reg.driveInD);
    end
  end

  // ************************************************************
  // Protection flags
  // ************************************************************
  // Thermal flags with hysteresis; nothing is flagged while powered down
  // Warning and shutdown thresholds
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      thermWarn_reg <= 1'h0;
      thermShut_reg <= 1'h0;
    end
    else if (state_reg == ST_PDN)
    begin
      thermWarn_reg <= 1'h0;
      thermShut_reg <= 1'h0;
    end
    else
    begin
      if (dieTempC > `CDB_TEMP_WARN_C)
        thermWarn_reg <= 1'h1;
      else if (dieTempC < `CDB_TEMP_CLEAR_C)
        thermWarn_reg <= 1'h0;
      if (dieTempC > `CDB_TEMP_SHUT_C)
        thermShut_reg <= 1'h1;
      else if (dieTempC < `CDB_TEMP_CLEAR_C)
        thermShut_reg <= 1'h0;
    end
  end

  // Mute release after an assertion clears the overcurrent latch
  assign muteRise = muteSeen_reg & pin_reg.muteN;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      muteSeen_reg <= 1'h0;
    else
      muteSeen_reg <= ~pin_reg.muteN;
  end

  // Set wins over the mute-release clear
  // Overcurrent trip
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      ocLatch_reg <= 1'h0;
    else if (state_reg == ST_PDN)
      ocLatch_reg <= 1'h0;
    else if (|currentLimitHit)
      ocLatch_reg <= 1'h1;
    else if (muteRise)
      ocLatch_reg <= 1'h0;
  end

  // Data-loss watch on the two bridge inputs
  logic [DL_W-1:0] dlCnt_reg;
  logic            inAPrev_reg;
  logic            inCPrev_reg;
  logic            toggled;

  assign toggled = (pin_reg.driveInA ^ inAPrev_reg) | (pin_reg.driveInC ^ inCPrev_reg);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      inAPrev_reg  <= 1'h0;
      inCPrev_reg  <= 1'h0;
      dlCnt_reg    <= '0;
      dataLoss_reg <= 1'h0;
    end
    else
    begin
      inAPrev_reg <= pin_reg.driveInA;
      inCPrev_reg <= pin_reg.driveInC;
      if (state_reg == ST_PDN || chanMode_reg || toggled)
      begin
        dlCnt_reg    <= '0;
        dataLoss_reg <= 1'h0;
      end
      else if (dlCnt_reg >= DL_W'(DATALOSS_CYC))
        dataLoss_reg <= 1'h1;
      else
        dlCnt_reg <= dlCnt_reg + DL_W'(1);
    end
  end

  // ************************************************************
  // Gate drive with dead time
  // ************************************************************
  logic       extPrev_reg;
  logic       tick;
  logic [3:0] level;
  logic [3:0] wantHi;
  logic [3:0] wantLo;
  logic       lowEnable;
  logic       run;
  logic [4:0] deadTicks;
  logic [4:0] dtCnt_reg [4];

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      extPrev_reg <= 1'h0;
    else
      extPrev_reg <= pin_reg.extClk;
  end

  assign tick = clkSrc_reg ? (pin_reg.extClk & ~extPrev_reg) : 1'h1;
  assign deadTicks = 5'(novIdx_reg * `CDB_NOV_STEP_TICKS);
  assign run = (state_reg == ST_RUN);

  // Target level of each output, bit 0 is A
  // Mode select
  assign level = chanMode_reg
               ? {pin_reg.driveInD, pin_reg.driveInC, pin_reg.driveInB, pin_reg.driveInA}
               : {~pin_reg.driveInC, pin_reg.driveInC, ~pin_reg.driveInA, pin_reg.driveInA};

  assign lowEnable = ~chanMode_reg | pin_reg.errIn[0];
  assign wantHi = {4{run}} & level;
  assign wantLo = {4{run & lowEnable}} & ~level;

  // Turning off is immediate; turning on waits for the dead time
  // Break before make
  for (genvar i = 0; i < 4; i++)
  begin : g_pair
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        bridgeOutHi[i] <= 1'h0;
        bridgeOutLo[i] <= 1'h0;
        dtCnt_reg[i]   <= 5'h00;
      end
      else if ((bridgeOutHi[i] & ~wantHi[i]) | (bridgeOutLo[i] & ~wantLo[i]))
      begin
        bridgeOutHi[i] <= bridgeOutHi[i] & wantHi[i];
        bridgeOutLo[i] <= bridgeOutLo[i] & wantLo[i];
        dtCnt_reg[i]   <= deadTicks;
      end
      else if (dtCnt_reg[i] != 5'h00)
      begin
        if (tick)
          dtCnt_reg[i] <= dtCnt_reg[i] - 5'h01;
      end
      else
      begin
        bridgeOutHi[i] <= wantHi[i];
        bridgeOutLo[i] <= wantLo[i];
      end
    end
  end

  // ************************************************************
  // Error pins
  // ************************************************************
  // Released during powerdown so the pull-ups and straps set the level
  // Strap then output
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {thermalShutdownNOe, thermalWarnNOe, overcurrentFlagNOe, datalossOrLowsideOe} <= 4'h0;
      {thermalShutdownNOut, thermalWarnNOut, overcurrentFlagNOut, datalossOrLowsideOut} <= 4'hF;
    end
    else
    begin
      thermalShutdownNOe   <= (state_reg != ST_PDN);
      thermalWarnNOe       <= (state_reg != ST_PDN);
      overcurrentFlagNOe   <= (state_reg != ST_PDN);
      datalossOrLowsideOe  <= (state_reg != ST_PDN) & ~chanMode_reg;
      thermalShutdownNOut  <= ~thermShut_reg;
      thermalWarnNOut      <= ~thermWarn_reg;
      overcurrentFlagNOut  <= ~ocLatch_reg;
      datalossOrLowsideOut <= ~dataLoss_reg;
    end
  end

  // ************************************************************
  // Register port
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      softMute_reg <= `CDB_CTRL_RESET;
    else if (regWrite && regAddr == `CDB_REG_CTRL)
      softMute_reg <= regWdata[`CDB_CTRL_SOFTMUTE];
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      regRdata <= 32'h0000_0000;
    else
    begin
      regRdata <= 32'h0000_0000;
      if (regRead)
      begin
        case (regAddr)
          `CDB_REG_CTRL:
            regRdata[`CDB_CTRL_SOFTMUTE] <= softMute_reg;
          `CDB_REG_STATUS:
          begin
            regRdata[`CDB_ST_DATALOSS]    <= dataLoss_reg;
            regRdata[`CDB_ST_OVERCURRENT] <= ocLatch_reg;
            regRdata[`CDB_ST_THERMWARN]   <= thermWarn_reg;
            regRdata[`CDB_ST_THERMSHUT]   <= thermShut_reg;
            regRdata[`CDB_ST_POWERDOWN]   <= (state_reg == ST_PDN);
            regRdata[`CDB_ST_MUTED]       <= (state_reg == ST_HALT);
          end
          `CDB_REG_CONFIG:
          begin
            regRdata[`CDB_CFG_CLKSRC] <= clkSrc_reg;
            regRdata[`CDB_CFG_CHMODE] <= chanMode_reg;
            regRdata[`CDB_CFG_EDGE_LSB +: 4] <= edgeSpeedIdx;
            regRdata[`CDB_CFG_NOV_LSB +: 4]  <= novIdx_reg;
          end
          default:
            regRdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_noShootThrough;
    @(posedge mclk) disable iff (!reset_n) (bridgeOutHi & bridgeOutLo) == 4'h0;
  endproperty
  a_noShootThrough: assert property (p_noShootThrough)
    else $error("High and low side of a pair both on");

  property p_deadGap;
    @(posedge mclk) disable iff (!reset_n)
      $fell(bridgeOutLo[0]) |-> !bridgeOutHi[0] ##1 !bridgeOutHi[0];
  endproperty
  a_deadGap: assert property (p_deadGap)
    else $error("High side turned on without dead time");

  property p_strapHold;
    @(posedge mclk) disable iff (!reset_n)
      (state_reg != ST_PDN) && $past(state_reg != ST_PDN) |-> $stable(chanMode_reg)
        && $stable(clkSrc_reg) && $stable(edgeSpeedIdx) && $stable(novIdx_reg);
  endproperty
  a_strapHold: assert property (p_strapHold)
    else $error("Captured strap changed outside powerdown");

  property p_warnSet;
    @(posedge mclk) disable iff (!reset_n)
      (state_reg != ST_PDN) && pin_reg.resetPowerdownN && dieTempC > `CDB_TEMP_WARN_C
        |=> thermWarn_reg;
  endproperty
  a_warnSet: assert property (p_warnSet)
    else $error("Thermal warning not raised above threshold");

  property p_shutStops;
    @(posedge mclk) disable iff (!reset_n)
      thermShut_reg ##1 thermShut_reg |=> bridgeOutHi == 4'h0 && bridgeOutLo == 4'h0;
  endproperty
  a_shutStops: assert property (p_shutStops)
    else $error("Switching continues in thermal shutdown");

  property p_hysteresis;
    @(posedge mclk) disable iff (!reset_n)
      thermShut_reg && pin_reg.resetPowerdownN && dieTempC >= `CDB_TEMP_CLEAR_C
        |=> thermShut_reg;
  endproperty
  a_hysteresis: assert property (p_hysteresis)
    else $error("Thermal shutdown cleared above clear threshold");

  property p_ocHold;
    @(posedge mclk) disable iff (!reset_n)
      ocLatch_reg && !muteRise && pin_reg.resetPowerdownN |=> ocLatch_reg;
  endproperty
  a_ocHold: assert property (p_ocHold)
    else $error("Overcurrent latch cleared without reset or mute cycle");

  property p_ocMutes;
    @(posedge mclk) disable iff (!reset_n)
      (|currentLimitHit) && (state_reg != ST_PDN) && pin_reg.resetPowerdownN
        |=> ##1 !overcurrentFlagNOut ##1 (bridgeOutHi == 4'h0);
  endproperty
  a_ocMutes: assert property (p_ocMutes)
    else $error("Overcurrent did not flag and mute");

  property p_lowDisable;
    @(posedge mclk) disable iff (!reset_n)
      chanMode_reg && !pin_reg.errIn[0] |=> bridgeOutLo == 4'h0;
  endproperty
  a_lowDisable: assert property (p_lowDisable)
    else $error("Low side on while disabled");

  property p_errFollows;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> thermalWarnNOut == !$past(thermWarn_reg);
  endproperty
  a_errFollows: assert property (p_errFollows)
    else $error("Warning pin not active low copy of flag");

  c_dataLoss: cover property (@(posedge mclk) disable iff (!reset_n) $rose(dataLoss_reg));
  c_ocTrip:   cover property (@(posedge mclk) disable iff (!reset_n) $rose(ocLatch_reg));
  c_thermal:  cover property (@(posedge mclk) disable iff (!reset_n) $fell(thermShut_reg));
  c_deadTime: cover property (@(posedge mclk) disable iff (!reset_n) $rose(bridgeOutHi[1]));

endmodule
`default_nettype wire

// ### sim/cdb_mod_model.sv
// Upstream modulator model: toggles A and C, or holds levels set by the bench.
// Assumes it shares mclk with the core and the bench owns its controls.
`default_nettype none
module cdb_mod_model (
  input  wire logic mclk,
  input  wire logic run,
  input  wire logic levA,
  input  wire logic levB,
  input  wire logic levC,
  input  wire logic levD,
  output logic      driveInA,
  output logic      driveInB,
  output logic      driveInC,
  output logic      driveInD
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  // Slow toggling keeps each level far longer than the filter and dead time
  always_ff @(posedge mclk)
  begin
    cnt <= cnt + 4'h1;
    if (!run)
    begin
      driveInA <= levA;
      driveInC <= levC;
    end
    else if (cnt == 4'hF)
    begin
      driveInA <= ~driveInA;
      driveInC <= ~driveInC;
    end
  end
  always_ff @(posedge mclk)
  begin
    driveInB <= levB;
    driveInD <= levD;
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Bench for the bridge control: straps, switching, flags and registers.
// Assumes the core, its package and the modulator model are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Stimulus and DUT
  // ****************
  logic        mclk = 1'b0;
  logic        extClk = 1'b0;
  logic        extRun = 1'b0;
  logic        reset_n, resetPowerdownN, muteN, clkSrc, chMode;
  logic        run, levA, levB, levC, levD;
  logic        ovcStrap, warnStrap, shutStrap, err0Drive;
  logic        regWrite, regRead;
  logic [7:0]  dieTempC, currentLimitHit, regAddr;
  logic [31:0] regWdata, regRdata, rd;
  logic [3:0]  hi, lo, edgeIdx;
  logic        drive_in_a, drive_in_b, inC, drive_in_d;
  logic        o0, e0, o1, e1, o2, e2, o3, e3;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [7:0]  temps [6] = '{8'h87, 8'h88, 8'h96, 8'h97, 8'h78, 8'h77};
  logic [5:0]  warnExp = 6'h21;
  logic [5:0]  shutExp = 6'h27;
  // error pins float to the resistor strap level whenever the core lets go
  wire         p0 = e0 ? o0 : err0Drive;
  wire         p1 = e1 ? o1 : ovcStrap;
  wire         p2 = e2 ? o2 : warnStrap;
  wire         p3 = e3 ? o3 : shutStrap;

  initial forever #25 mclk = ~mclk;
  // clock pin stays quiet until the external source is strapped
  initial forever #70 extClk = extRun & ~extClk;

  cdb_mod_model modl (.mclk(mclk), .run(run), .levA(levA), .levB(levB), .levC(levC),
    .levD(levD), .driveInA(drive_in_a), .driveInB(drive_in_b), .driveInC(inC), .driveInD(drive_in_d));

  cdb_bridge_ctrl #(.DATALOSS_CYC(200)) dut (.mclk(mclk), .reset_n(reset_n),
    .driveInA(drive_in_a), .driveInB(drive_in_b), .driveInC(inC), .driveInD(drive_in_d), .muteN(muteN),
    .resetPowerdownN(resetPowerdownN), .extClk(extClk), .clockSourceStrap(clkSrc),
    .channelModeStrap(chMode), .dieTempC(dieTempC), .currentLimitHit(currentLimitHit),
    .datalossOrLowsideIn(p0), .datalossOrLowsideOut(o0), .datalossOrLowsideOe(e0),
    .overcurrentFlagNIn(p1), .overcurrentFlagNOut(o1), .overcurrentFlagNOe(e1),
    .thermalWarnNIn(p2), .thermalWarnNOut(o2), .thermalWarnNOe(e2),
    .thermalShutdownNIn(p3), .thermalShutdownNOut(o3), .thermalShutdownNOe(e3),
    .bridgeOutHi(hi), .bridgeOutLo(lo), .edgeSpeedIdx(edgeIdx), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Run is about 1100 cycles; the ceiling leaves wide margin
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdReg(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    rd = regRdata;
  endtask

  // Pattern with A high and C low: A and D on high side, B and C low side
  task automatic chkGates(input logic on);
    chk("gates high", 32'(hi), on ? 32'h9 : 32'h0);
    chk("gates low", 32'(lo), on ? 32'h6 : 32'h0);
  endtask

  // Cycles from low side off to high side on, at nonoverlap index 3
  task automatic deadTime();
    int n;
    n = 0;
    @(posedge mclk);
    levA <= 1'b0;
    tick(30);
    levA <= 1'b1;
    while (lo[0] !== 1'b0 && n < 40)
    begin
      tick(1);
      n++;
    end
    n = 0;
    while (hi[0] !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk("dead cycles", 32'(n), 32'h7);
  endtask

  // ****************
  // Test sequence
  // ****************
  initial
  begin
    reset_n = 1'b0;
    resetPowerdownN = 1'b0;
    muteN = 1'b1;
    {clkSrc, chMode, run, levA, levB, levC, levD} = 7'b0001001;
    {ovcStrap, warnStrap, shutStrap, err0Drive} = 4'b0011;
    dieTempC = 8'h19;
    currentLimitHit = 8'h00;
    {regAddr, regWdata, regWrite, regRead} = '0;
    tick(20);
    reset_n <= 1'b1;
    tick(10);
    resetPowerdownN <= 1'b1;
    tick(20);
    clkSrc <= 1'b1;
    chMode <= 1'b1;
    levB <= 1'b1;
    tick(20);
    rdReg(8'h08);
    chk("config", {20'h0, rd[11:0]}, 32'h360);
    chk("edge index", 32'(edgeIdx), 32'h6);
    chk("error oe", {28'h0, e3, e2, e1, e0}, 32'hF);
    chk("flags idle", {28'h0, o3, o2, o1, o0}, 32'hF);
    chkGates(1'b1);
    deadTime();
    run <= 1'b1;
    tick(300);
    chk("data kept", 32'(o0), 32'h1);
    run <= 1'b0;
    tick(250);
    chk("data lost", 32'(o0), 32'h0);
    rdReg(8'h04);
    chk("status loss", 32'(rd[0]), 32'h1);
    chkGates(1'b1);
    foreach (temps[i])
    begin
      dieTempC <= temps[i];
      tick(20);
      chk("warn", 32'(o2), 32'(warnExp[i]));
      chk("shutdown", 32'(o3), 32'(shutExp[i]));
      chkGates(shutExp[i]);
    end
    currentLimitHit <= 8'h10;
    tick(3);
    currentLimitHit <= 8'h00;
    tick(20);
    chk("overcurrent", 32'(o1), 32'h0);
    chkGates(1'b0);
    muteN <= 1'b0;
    tick(20);
    chkGates(1'b0);
    muteN <= 1'b1;
    tick(20);
    chk("overcurrent", 32'(o1), 32'h1);
    chkGates(1'b1);
    wr(8'h00, 32'h1);
    tick(20);
    chkGates(1'b0);
    rdReg(8'h00);
    chk("ctrl", rd, 32'h1);
    rdReg(8'h04);
    chk("status", rd, 32'h21);
    wr(8'h00, 32'h0);
    rdReg(8'h0C);
    chk("unmapped", rd, 32'h0);
    resetPowerdownN <= 1'b0;
    extRun <= 1'b1;
    levD <= 1'b0;
    {ovcStrap, warnStrap} <= 2'b11;
    tick(10);
    resetPowerdownN <= 1'b1;
    tick(10);
    levB <= 1'b0;
    levD <= 1'b1;
    tick(150);
    chkGates(1'b1);
    chk("low pin oe", 32'(e0), 32'h0);
    rdReg(8'h08);
    chk("config", {20'h0, rd[11:0]}, 32'h873);
    chk("edge index", 32'(edgeIdx), 32'h7);
    err0Drive <= 1'b0;
    tick(20);
    chk("low sides off", 32'(lo), 32'h0);
    chk("high sides", 32'(hi), 32'h9);
    finish_test();
  end
endmodule
`default_nettype wire
